// ---- verilog/pm_caps_pkg.sv ----
/*
  Constants, register offsets, field positions and carrier types for the
  per-port power-management capability block. Assumes one core clock and
  an active-low fundamental reset.
*/
// What this block does
// - in D0 the link stays in L0 unless ASPM lowers it.
// - D0 allows L0, L0s or ASPM L1; D1 and D2 allow L1; D3hot allows L1 or L2/L3 Ready.
// - D3cold link is L2 with auxiliary power, L3 without it.
// - transmit L0s puts transmit lanes into high impedance.
// - receive L0s puts receive lanes into low power.
// - L1 and L2/L3 Ready put receive lanes into low power and halt FC timers; clocks may stop in L2/L3 Ready only.
// - software writing D1, D2 or D3hot moves the link into L1.
// - L2/L3 Ready follows D3hot once the turn-off message arrives; L2 or L3 follows once main power goes off.
// - capability ID bits 7:0 at 40h read 01h.
// - next-capability pointer defaults to 48h.
// - version field bits 18:16 reads 011b.
// - aux current reads 000b when data is implemented or D3cold wake unsupported.
// - D1 and D2 support bits 25 and 26 read 1.
// - PME support bits 31, 30 and 27 read 1.
// - power-state bits 1:0 at 44h report and select D0 to D3hot.
// - no-soft-reset bit 3 reads 1.
// - bit 8 enables PME generation; bit 15 shows PME being generated.
// - data select is serial-only writable until a serial write, then read-write.
// - four serial-written scale/data entries per port, others read 00h.
// - upstream port captures slot power limit value and scale at 6Ch.
// - ASPM support bits 11:10 at 74h report L0s and L1.
// - L0s exit latency from fast-training count; L1 exit latency from link speed.
package pm_caps_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_PM_CAP = 12'h040;
  localparam logic [11:0] OFS_PM_CSR = 12'h044;
  localparam logic [11:0] OFS_DEV_CAP = 12'h06C;
  localparam logic [11:0] OFS_DEV_CTL = 12'h070;
  localparam logic [11:0] OFS_LINK_CAP = 12'h074;

  // ---------------------------------------------------------------
  // fixed field values
  // ---------------------------------------------------------------
  localparam logic [7:0] CAP_ID = 8'h01;
  localparam logic [7:0] NEXT_PTR = 8'h48;
  localparam logic [2:0] PM_VERSION = 3'h3;
  localparam logic [4:0] PME_SUPPORT = 5'h19;
  localparam logic [1:0] ASPM_SUPPORT = 2'h3;
  localparam logic [2:0] L1_LAT_GEN2 = 3'h1;
  localparam logic [2:0] L1_LAT_GEN1 = 3'h2;
  localparam logic WAKE_D3COLD = 1'b1;
  localparam int NUM_ENTRIES = 4;

  // ---------------------------------------------------------------
  // exit latency timing, symbol times in ns
  // ---------------------------------------------------------------
  localparam int SYM_NS_GEN1 = 4;
  localparam int SYM_NS_GEN2 = 2;
  localparam int SYM_PER_FTS = 4;
  localparam logic [12:0] LAT_64NS = 13'h0040;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] RST_PSTATE = 2'h0;
  localparam logic [3:0] RST_SEL = 4'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {D0, D1, D2, D3HOT} dstate_t;
  typedef enum {LK_L0, LK_L0S, LK_L1, LK_L23RDY, LK_L2, LK_L3} link_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] value;
    logic [1:0] scale;
  } slot_msg_t;

  typedef struct packed {
    logic [2:0] state;
    logic tx_hiz;
    logic rx_lowpwr;
    logic fc_halt;
    logic clk_stop_ok;
    logic pme_req;
  } phy_ctl_t;

endpackage

// ---- verilog/pm_caps.sv ----
/*
  Power-management state mapping and capability registers of one switch
  port. Configuration reads and writes arrive on the cfg port; serial
  EEPROM and I2C writes arrive on the ser port. Link events come from the
  link layer and are synchronous to clk_i.
*/
`timescale 1ns/10ps
module pm_caps (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // port role
  input wire logic upstream_port_i,
  // configuration access
  input wire pm_caps_pkg::cfg_req_t cfg_req_i,
  output pm_caps_pkg::cfg_rsp_t cfg_rsp_o,
  // serial eeprom and i2c writes
  input wire pm_caps_pkg::cfg_req_t ser_req_i,
  // slot power limit message
  input wire pm_caps_pkg::slot_msg_t slot_msg_i,
  // link events
  input wire logic [1:0] aspm_ctl_i,
  input wire logic tx_idle_i,
  input wire logic rx_idle_i,
  input wire logic aspm_l1_req_i,
  input wire logic l1_exit_i,
  input wire logic turn_off_i,
  input wire logic main_off_i,
  input wire logic vaux_present_i,
  input wire logic gen2_i,
  input wire logic [7:0] n_fts_i,
  input wire logic pme_event_i,
  // link power control
  output pm_caps_pkg::phy_ctl_t phy_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pstate;
    logic pme_en;
    logic pme_status;
    logic [3:0] sel;
    logic sel_unlocked;
    logic data_impl;
    logic [pm_caps_pkg::NUM_ENTRIES-1:0][1:0] scale;
    logic [pm_caps_pkg::NUM_ENTRIES-1:0][7:0] data;
    logic [2:0] aux_cur;
    logic aux_pm_en;
    logic [7:0] slot_val;
    logic [1:0] slot_scale;
    pm_caps_pkg::link_t link;
    logic aspm_l1;
    logic rsp_valid;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // ---------------------------------------------------------------
  // decoded accesses
  // ---------------------------------------------------------------
  logic cfg_wr;
  logic cfg_rd;
  logic ser_wr;
  logic cfg_csr;
  logic ser_csr;
  logic [31:0] rd_word;
  logic [7:0] sel_data;
  logic [1:0] sel_scale;
  logic sel_in_range;

  assign cfg_wr = cfg_req_i.valid & cfg_req_i.write;
  assign cfg_rd = cfg_req_i.valid & ~cfg_req_i.write;
  assign ser_wr = ser_req_i.valid & ser_req_i.write;
  assign cfg_csr = cfg_wr & (cfg_req_i.addr == pm_caps_pkg::OFS_PM_CSR);
  assign ser_csr = ser_wr & (ser_req_i.addr == pm_caps_pkg::OFS_PM_CSR);

  // ---------------------------------------------------------------
  // power data entry selection
  // ---------------------------------------------------------------
  assign sel_in_range = (st.sel < 4'(pm_caps_pkg::NUM_ENTRIES));
  assign sel_data = sel_in_range ? st.data[st.sel[1:0]] : 8'h00;
  assign sel_scale = sel_in_range ? st.scale[st.sel[1:0]] : 2'h0;

  // ---------------------------------------------------------------
  // exit latency encodings
  // ---------------------------------------------------------------
  logic [12:0] l0s_ns;
  logic [2:0] l0s_lat;
  logic [2:0] l1_lat;

  always_comb begin
    l0s_ns = 13'(n_fts_i) * 13'(pm_caps_pkg::SYM_PER_FTS)
      * (gen2_i ? 13'(pm_caps_pkg::SYM_NS_GEN2) : 13'(pm_caps_pkg::SYM_NS_GEN1));
    if (l0s_ns < pm_caps_pkg::LAT_64NS) begin
      l0s_lat = 3'h0;
    end else if (l0s_ns < (pm_caps_pkg::LAT_64NS << 1)) begin
      l0s_lat = 3'h1;
    end else if (l0s_ns < (pm_caps_pkg::LAT_64NS << 2)) begin
      l0s_lat = 3'h2;
    end else if (l0s_ns < (pm_caps_pkg::LAT_64NS << 3)) begin
      l0s_lat = 3'h3;
    end else if (l0s_ns < (pm_caps_pkg::LAT_64NS << 4)) begin
      l0s_lat = 3'h4;
    end else if (l0s_ns < (pm_caps_pkg::LAT_64NS << 5)) begin
      l0s_lat = 3'h5;
    end else if (l0s_ns < (pm_caps_pkg::LAT_64NS << 6)) begin
      l0s_lat = 3'h6;
    end else begin
      l0s_lat = 3'h7;
    end
    l1_lat = gen2_i ? pm_caps_pkg::L1_LAT_GEN2 : pm_caps_pkg::L1_LAT_GEN1;
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [2:0] aux_cur_rd;

  assign aux_cur_rd = (st.data_impl | ~pm_caps_pkg::WAKE_D3COLD) ? 3'h0 : st.aux_cur;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (cfg_req_i.addr)
      pm_caps_pkg::OFS_PM_CAP: begin
        rd_word[7:0] = pm_caps_pkg::CAP_ID;
        rd_word[15:8] = pm_caps_pkg::NEXT_PTR;
        rd_word[18:16] = pm_caps_pkg::PM_VERSION;
        rd_word[24:22] = aux_cur_rd;
        rd_word[25] = 1'b1;
        rd_word[26] = 1'b1;
        rd_word[31:27] = pm_caps_pkg::PME_SUPPORT;
      end
      pm_caps_pkg::OFS_PM_CSR: begin
        rd_word[1:0] = st.pstate;
        rd_word[3] = 1'b1;
        rd_word[8] = st.pme_en;
        rd_word[12:9] = st.sel;
        rd_word[14:13] = sel_scale;
        rd_word[15] = st.pme_status;
        rd_word[23:22] = 2'h0;
        rd_word[31:24] = sel_data;
      end
      pm_caps_pkg::OFS_DEV_CAP: begin
        rd_word[11:6] = 6'h00;
        rd_word[25:18] = st.slot_val;
        rd_word[27:26] = st.slot_scale;
      end
      pm_caps_pkg::OFS_DEV_CTL: begin
        rd_word[10] = st.aux_pm_en;
        rd_word[20] = vaux_present_i;
      end
      pm_caps_pkg::OFS_LINK_CAP: begin
        rd_word[11:10] = pm_caps_pkg::ASPM_SUPPORT;
        rd_word[14:12] = l0s_lat;
        rd_word[17:15] = l1_lat;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rsp_valid = cfg_rd;
    next_st.rdata = cfg_rd ? rd_word : st.rdata;

    // configuration writes to status/control
    if (cfg_csr && cfg_req_i.be[0]) begin
      next_st.pstate = cfg_req_i.wdata[1:0];
    end
    if (cfg_csr && cfg_req_i.be[1]) begin
      next_st.pme_en = cfg_req_i.wdata[8];
      if (st.sel_unlocked) begin
        next_st.sel = cfg_req_i.wdata[12:9];
      end
    end

    // serial writes to status/control and data entries
    if (ser_csr && ser_req_i.be[1]) begin
      next_st.sel = ser_req_i.wdata[12:9];
      next_st.sel_unlocked = 1'b1;
    end
    if (ser_csr && (ser_req_i.be[1] || ser_req_i.be[3])) begin
      if (ser_req_i.wdata[12:9] < 4'(pm_caps_pkg::NUM_ENTRIES)) begin
        if (ser_req_i.be[1]) begin
          next_st.scale[ser_req_i.wdata[10:9]] = ser_req_i.wdata[14:13];
        end
        if (ser_req_i.be[3]) begin
          next_st.data[ser_req_i.wdata[10:9]] = ser_req_i.wdata[31:24];
        end
      end
    end
    if (ser_csr && ser_req_i.be[3]) begin
      next_st.data_impl = 1'b1;
    end
    if (ser_wr && (ser_req_i.addr == pm_caps_pkg::OFS_PM_CAP) && ser_req_i.be[2]) begin
      next_st.aux_cur[1:0] = ser_req_i.wdata[23:22];
    end
    if (ser_wr && (ser_req_i.addr == pm_caps_pkg::OFS_PM_CAP) && ser_req_i.be[3]) begin
      next_st.aux_cur[2] = ser_req_i.wdata[24];
    end

    // device control
    if (cfg_wr && (cfg_req_i.addr == pm_caps_pkg::OFS_DEV_CTL) && cfg_req_i.be[1]) begin
      next_st.aux_pm_en = cfg_req_i.wdata[10];
    end

    // pme status, set wins over clear
    if (cfg_csr && cfg_req_i.be[1] && cfg_req_i.wdata[15]) begin
      next_st.pme_status = 1'b0;
    end
    if (pme_event_i && st.pme_en) begin
      next_st.pme_status = 1'b1;
    end

    // captured slot power limit on the upstream port
    if (slot_msg_i.valid && upstream_port_i) begin
      next_st.slot_val = slot_msg_i.value;
      next_st.slot_scale = slot_msg_i.scale;
    end

    // link state tracking
    case (st.link)
      pm_caps_pkg::LK_L0: begin
        if (st.pstate != pm_caps_pkg::D0) begin
          next_st.link = pm_caps_pkg::LK_L1;
          next_st.aspm_l1 = 1'b0;
        end else if (aspm_l1_req_i && aspm_ctl_i[1]) begin
          next_st.link = pm_caps_pkg::LK_L1;
          next_st.aspm_l1 = 1'b1;
        end else if (tx_idle_i && aspm_ctl_i[0]) begin
          next_st.link = pm_caps_pkg::LK_L0S;
        end else begin
          next_st.link = pm_caps_pkg::LK_L0;
        end
      end
      pm_caps_pkg::LK_L0S: begin
        if (st.pstate != pm_caps_pkg::D0) begin
          next_st.link = pm_caps_pkg::LK_L1;
          next_st.aspm_l1 = 1'b0;
        end else if (!tx_idle_i || !aspm_ctl_i[0]) begin
          next_st.link = pm_caps_pkg::LK_L0;
        end
      end
      pm_caps_pkg::LK_L1: begin
        if (st.pstate == pm_caps_pkg::D0) begin
          if (!st.aspm_l1 || l1_exit_i) begin
            next_st.link = pm_caps_pkg::LK_L0;
            next_st.aspm_l1 = 1'b0;
          end
        end else if (turn_off_i && st.pstate == pm_caps_pkg::D3HOT) begin
          next_st.link = pm_caps_pkg::LK_L23RDY;
        end
      end
      pm_caps_pkg::LK_L23RDY: begin
        if (main_off_i) begin
          next_st.link = vaux_present_i ? pm_caps_pkg::LK_L2 : pm_caps_pkg::LK_L3;
        end else if (st.pstate == pm_caps_pkg::D0) begin
          next_st.link = pm_caps_pkg::LK_L0;
        end
      end
      pm_caps_pkg::LK_L2: begin
        if (!vaux_present_i) begin
          next_st.link = pm_caps_pkg::LK_L3;
        end
      end
      pm_caps_pkg::LK_L3: begin
        next_st.link = pm_caps_pkg::LK_L3;
      end
      default: begin
        next_st.link = pm_caps_pkg::LK_L0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st.pstate <= pm_caps_pkg::RST_PSTATE;
      st.pme_en <= 1'b0;
      st.pme_status <= 1'b0;
      st.sel <= pm_caps_pkg::RST_SEL;
      st.sel_unlocked <= 1'b0;
      st.data_impl <= 1'b0;
      st.scale <= '0;
      st.data <= '0;
      st.aux_cur <= 3'h0;
      st.aux_pm_en <= 1'b0;
      st.slot_val <= 8'h00;
      st.slot_scale <= 2'h0;
      st.link <= pm_caps_pkg::LK_L0;
      st.aspm_l1 <= 1'b0;
      st.rsp_valid <= 1'b0;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic deep_idle;

  assign deep_idle = (st.link == pm_caps_pkg::LK_L1) || (st.link == pm_caps_pkg::LK_L23RDY);

  assign cfg_rsp_o.valid = st.rsp_valid;
  assign cfg_rsp_o.rdata = st.rdata;

  assign phy_o.state = 3'(st.link);
  assign phy_o.tx_hiz = (st.link == pm_caps_pkg::LK_L0S);
  assign phy_o.rx_lowpwr = deep_idle
    || (rx_idle_i && ((st.link == pm_caps_pkg::LK_L0) || (st.link == pm_caps_pkg::LK_L0S)));
  assign phy_o.fc_halt = deep_idle;
  assign phy_o.clk_stop_ok = (st.link == pm_caps_pkg::LK_L23RDY);
  assign phy_o.pme_req = st.pme_status & st.pme_en;

endmodule

// ---- test/pm_caps_props.sv ----
/*
  Checker for the power-management capability block, bound to pm_caps.
  Assumes a single core clock and the active-low reset of that domain.
*/
`timescale 1ns/10ps
module pm_caps_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire pm_caps_pkg::cfg_req_t cfg_req_i,
  input wire pm_caps_pkg::cfg_rsp_t cfg_rsp_o,
  input wire logic tx_idle_i,
  input wire logic aspm_l1_req_i,
  input wire logic turn_off_i,
  input wire logic main_off_i,
  input wire logic vaux_present_i,
  input wire pm_caps_pkg::phy_ctl_t phy_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd;
  logic psw;
  assign rd = cfg_req_i.valid && !cfg_req_i.write;
  assign psw = cfg_req_i.valid && cfg_req_i.write && cfg_req_i.addr == pm_caps_pkg::OFS_PM_CSR && cfg_req_i.be[0];
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_read_answer: assert property (rd |=> cfg_rsp_o.valid) else $error("read not answered");
  a_rsp_cause: assert property (cfg_rsp_o.valid |-> $past(rd)) else $error("answer without read");
  a_cap_fixed: assert property (rd && cfg_req_i.addr == pm_caps_pkg::OFS_PM_CAP |=>
    cfg_rsp_o.rdata[15:0] == 16'h4801 && cfg_rsp_o.rdata[18:16] == 3'h3 && cfg_rsp_o.rdata[31:25] == 7'h67)
    else $error("capability fields wrong");
  a_csr_fixed: assert property (rd && cfg_req_i.addr == pm_caps_pkg::OFS_PM_CSR |=>
    cfg_rsp_o.rdata[3] && cfg_rsp_o.rdata[23:22] == 2'h0) else $error("status fixed bits wrong");
  a_devcap_zero: assert property (rd && cfg_req_i.addr == pm_caps_pkg::OFS_DEV_CAP |=>
    cfg_rsp_o.rdata[11:6] == 6'h00) else $error("latency fields not zero");
  a_tx_hiz: assert property (phy_o.state == 3'h1 |-> phy_o.tx_hiz) else $error("tx not hiz in L0s");
  a_l1_idle: assert property (phy_o.state inside {3'h2, 3'h3} |-> phy_o.fc_halt && phy_o.rx_lowpwr)
    else $error("lanes not idle in L1");
  a_sw_l1: assert property (psw && cfg_req_i.wdata[1:0] != 2'h0 && phy_o.state < 3'h2 ##1 !main_off_i |=>
    phy_o.state == 3'h2) else $error("no L1 after power state write");
  a_turnoff_l23: assert property (phy_o.state == 3'h2 ##1 phy_o.state == 3'h3 |-> $past(turn_off_i))
    else $error("L2/L3 ready without turn-off");
  a_d3cold_aux: assert property (phy_o.state == 3'h3 && main_off_i |=>
    phy_o.state == ($past(vaux_present_i) ? 3'h4 : 3'h5)) else $error("wrong D3cold link state");
  a_l3_held: assert property (phy_o.state == 3'h5 |=> phy_o.state == 3'h5) else $error("L3 left");
  a_l0_hold: assert property (phy_o.state == 3'h0 && !tx_idle_i && !aspm_l1_req_i && !main_off_i && !psw && !$past(psw) |=>
    phy_o.state == 3'h0) else $error("L0 left without cause");
  c_l0s: cover property (phy_o.state == 3'h1);
  c_l2: cover property (phy_o.state == 3'h4);
  c_l3: cover property (phy_o.state == 3'h5);
endmodule

bind pm_caps pm_caps_props pm_caps_props_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_req_i(cfg_req_i),
  .cfg_rsp_o(cfg_rsp_o), .tx_idle_i(tx_idle_i), .aspm_l1_req_i(aspm_l1_req_i), .turn_off_i(turn_off_i),
  .main_off_i(main_off_i), .vaux_present_i(vaux_present_i), .phy_o(phy_o));

// ---- test/pm_link_partner.sv ----
/*
  Behavioural link partner and platform: idle, ASPM, turn-off and power
  events toward the port. Assumes callers enter tasks between clock edges.
*/
`timescale 1ns/10ps
module pm_link_partner (
  // clock
  input wire logic clk_i,
  // link events
  output logic tx_idle_o,
  output logic rx_idle_o,
  output logic l1_req_o,
  output logic l1_exit_o,
  output logic turn_off_o,
  // power rails
  output logic main_off_o,
  output logic vaux_o
);
  initial begin
    {tx_idle_o, rx_idle_o, l1_req_o, l1_exit_o, turn_off_o, main_off_o} = 6'h00;
    vaux_o = 1'b1;
  end
  task automatic lvl(logic tx, logic rx, logic l1);
    @(posedge clk_i);
    tx_idle_o <= tx;
    rx_idle_o <= rx;
    l1_req_o <= l1;
  endtask
  task automatic exit_l1();
    @(posedge clk_i);
    l1_exit_o <= 1'b1;
    @(posedge clk_i);
    l1_exit_o <= 1'b0;
  endtask
  // turn-off sent for one clock after a chosen delay, whatever the port's power state
  task automatic turn_off(int dly);
    repeat (dly) @(posedge clk_i);
    turn_off_o <= 1'b1;
    @(posedge clk_i);
    turn_off_o <= 1'b0;
  endtask
  task automatic power(logic off, logic aux);
    @(posedge clk_i);
    main_off_o <= off;
    vaux_o <= aux;
  endtask
endmodule

// ---- test/pm_caps_test.sv ----
/*
  Self-checking bench for pm_caps with a behavioural link partner.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/10ps
module pm_caps_test;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
  localparam logic [11:0] CAP = pm_caps_pkg::OFS_PM_CAP;
  localparam logic [11:0] CSR = pm_caps_pkg::OFS_PM_CSR;
  logic clk, rst_n, up, gen2, pme, tx_idle, rx_idle, l1_req, l1_exit, turn_off, main_off, vaux;
  logic [1:0] aspm;
  logic [7:0] nfts, v;
  logic [7:0] dat [4];
  logic [1:0] scl [4];
  pm_caps_pkg::cfg_req_t req, ser;
  pm_caps_pkg::cfg_rsp_t rsp;
  pm_caps_pkg::slot_msg_t slot;
  pm_caps_pkg::phy_ctl_t phy;
  note_t q[$];
  note_t nt;
  int n_errors, tests_run, ns, enc;
  pm_caps pm_caps_i (.clk_i(clk), .rst_n_i(rst_n), .upstream_port_i(up), .cfg_req_i(req), .cfg_rsp_o(rsp),
    .ser_req_i(ser), .slot_msg_i(slot), .aspm_ctl_i(aspm), .tx_idle_i(tx_idle), .rx_idle_i(rx_idle),
    .aspm_l1_req_i(l1_req), .l1_exit_i(l1_exit), .turn_off_i(turn_off), .main_off_i(main_off),
    .vaux_present_i(vaux), .gen2_i(gen2), .n_fts_i(nfts), .pme_event_i(pme), .phy_o(phy));
  pm_link_partner pm_link_partner_i (.clk_i(clk), .tx_idle_o(tx_idle), .rx_idle_o(rx_idle), .l1_req_o(l1_req),
    .l1_exit_o(l1_exit), .turn_off_o(turn_off), .main_off_o(main_off), .vaux_o(vaux));
  // ----------------------------------------
  // clock, tasks, answer monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(bit s, logic [11:0] a, logic [3:0] be, logic [31:0] d);
    @(posedge clk);
    if (s) ser <= '{1'b1, 1'b1, a, be, d};
    else req <= '{1'b1, be != 4'h0, a, be, d};
    @(posedge clk);
    ser.valid <= 1'b0;
    req.valid <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m);
    q.push_back('{e, m});
    xfer(1'b0, a, 4'h0, 32'h0);
  endtask
  task automatic st(logic [2:0] e);
    @(negedge clk);
    chk("state", 32'(e), 32'(phy.state));
  endtask
  task automatic pulse_pme();
    @(posedge clk);
    pme <= 1'b1;
    @(posedge clk);
    pme <= 1'b0;
  endtask
  task automatic slot_send(logic u, logic [7:0] val, logic [1:0] sc, logic [31:0] e);
    @(posedge clk);
    up <= u;
    slot <= '{1'b1, val, sc};
    @(posedge clk);
    slot.valid <= 1'b0;
    rd(pm_caps_pkg::OFS_DEV_CAP, e, 32'h0FFC_0FC0);
  endtask
  always @(posedge clk) begin
    if (rsp.valid === 1'b1) begin
      nt = q.pop_front();
      chk("rdata", nt.e & nt.m, rsp.rdata & nt.m);
    end
  end
  initial begin
    wt(20000);
    n_errors++;
    end_sim();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {n_errors, tests_run} = '0;
    {rst_n, up, gen2, pme, aspm, nfts} = '0;
    {req, ser, slot} = '0;
    ns = $urandom(42);
    wt(6);
    rst_n <= 1'b1;
    xfer(1'b0, CAP, 4'hF, 32'h0);
    rd(CAP, 32'hCE03_4801, 32'hFFEF_FFFF);
    rd(CSR, 32'h0000_0008, 32'hFFC0_FF0B);
    xfer(1'b0, CSR, 4'h2, 32'h0000_0400);
    rd(CSR, 32'h0, 32'h0000_1E00);
    xfer(1'b1, CAP, 4'hC, 32'h01C0_0000);
    rd(CAP, 32'h01C0_0000, 32'h01C0_0000);
    for (int i = 0; i < 4; i++) begin
      dat[i] = 8'($urandom);
      scl[i] = 2'($urandom);
      xfer(1'b1, CSR, 4'hA, {dat[i], 8'h0, 1'b0, scl[i], 4'(i), 9'h0});
    end
    rd(CAP, 32'h0, 32'h01C0_0000);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, CSR, 4'h2, {19'h0, 4'(i), 9'h0});
      rd(CSR, i < 4 ? {dat[i], 9'h0, scl[i], 4'(i), 9'h0} : {19'h0, 4'(i), 9'h0}, 32'hFF00_7E00);
    end
    pulse_pme();
    rd(CSR, 32'h0, 32'h0000_8100);
    xfer(1'b0, CSR, 4'h2, 32'h0000_0100);
    pulse_pme();
    rd(CSR, 32'h0000_8100, 32'h0000_8100);
    chk("pme_req", 32'h1, 32'(phy.pme_req));
    xfer(1'b0, CSR, 4'h2, 32'h0000_8100);
    rd(CSR, 32'h0000_0100, 32'h0000_8100);
    for (int d = 1; d < 4; d++) begin
      xfer(1'b0, CSR, 4'h1, 32'(d));
      wt(1);
      st(3'h2);
      chk("lowpwr", 32'h3, {30'h0, phy.fc_halt, phy.rx_lowpwr});
      rd(CSR, 32'(d), 32'h3);
      if (d < 3) begin
        xfer(1'b0, CSR, 4'h1, 32'h0);
        wt(1);
        st(3'h0);
      end
    end
    pm_link_partner_i.turn_off(3);
    st(3'h3);
    chk("clk_stop_ok", 32'h1, 32'(phy.clk_stop_ok));
    pm_link_partner_i.power(1'b1, 1'b1);
    wt(1);
    st(3'h4);
    pm_link_partner_i.power(1'b1, 1'b0);
    wt(3);
    st(3'h5);
    rst_n <= 1'b0;
    pm_link_partner_i.power(1'b0, 1'b1);
    wt(2);
    rst_n <= 1'b1;
    st(3'h0);
    rd(CSR, 32'h8, 32'hFF00_FF0B);
    aspm <= 2'h1;
    pm_link_partner_i.lvl(1'b1, 1'b1, 1'b0);
    wt(1);
    st(3'h1);
    chk("tx_rx", 32'h3, {30'h0, phy.tx_hiz, phy.rx_lowpwr});
    pm_link_partner_i.lvl(1'b0, 1'b0, 1'b0);
    aspm <= 2'h2;
    wt(1);
    st(3'h0);
    pm_link_partner_i.lvl(1'b0, 1'b0, 1'b1);
    wt(1);
    st(3'h2);
    pm_link_partner_i.lvl(1'b0, 1'b0, 1'b0);
    pm_link_partner_i.exit_l1();
    aspm <= 2'h0;
    st(3'h0);
    pm_link_partner_i.lvl(1'b1, 1'b0, 1'b1);
    wt(3);
    st(3'h0);
    pm_link_partner_i.lvl(1'b0, 1'b0, 1'b0);
    v = 8'($urandom);
    slot_send(1'b0, v, 2'h2, 32'h0);
    slot_send(1'b1, v, 2'h3, {4'h0, 2'h3, v, 18'h0});
    xfer(1'b0, pm_caps_pkg::OFS_DEV_CTL, 4'h2, 32'h0000_0400);
    rd(pm_caps_pkg::OFS_DEV_CTL, 32'h0010_0400, 32'h0010_0400);
    for (int g = 0; g < 2; g++) begin
      v = 8'($urandom);
      @(posedge clk);
      gen2 <= g[0];
      nfts <= v;
      ns = int'(v) * 4 * (g == 1 ? 2 : 4);
      enc = 0;
      for (int t = 64; ns >= t && enc < 7; t = t * 2) enc++;
      rd(pm_caps_pkg::OFS_LINK_CAP, {14'h0, g == 1 ? 3'h1 : 3'h2, 3'(enc), 2'h3, 10'h0}, 32'h0003_FC00);
    end
    rd(12'h100, 32'h0, 32'hFFFF_FFFF);
    wt(3);
    chk("pending", 32'h0, 32'(q.size()));
    end_sim();
  end
endmodule
